// ==== mctc_core.sv ====
/*
 * Counting core of a five-channel 16-bit timer: counters, general
 * compare/capture registers with buffering, run and synchronization control.
 * Assumes an APB master on pclk, count ticks and capture strobes synchronous
 * to pclk, and a standby level that reinitialises the registers.
 */
`timescale 1ns/1ps

// Operation
// - Five 16-bit count registers, one per channel.
// - Counts clear to zero on reset, standby and enabled clear requests.
// - Channel 0 counts up; channels 1, 2 count down only in up/down modes.
// - Channels 3, 4 count down only in complementary PWM mode.
// - Each general register is 16 bits, compare or capture.
// - Sixteen general registers: four for channels 0, 3, 4, two for 1, 2.
// - Registers C and D buffer A and B on channels 0, 3, 4.
// - General registers set to all ones on reset and standby.
// - Run register bit per channel; one counts, zero halts; resets zero.
// - Bits 5 to 3 of run and sync registers read zero.
// - Halting a channel outside PWM modes keeps its pin at its current level.
// - Pin control write while halted drives the initial level.
// - In PWM modes, halting returns the pin to its initial level.
// - Sync register bit per channel; zero means independent operation.
// - Synchronized channels preset and clear together.
// - Sync register resets to zero on reset and standby.
// - Overflow flag sets when a counter wraps from all ones to zero.
// - Underflow flag sets on channels 1, 2 when wrapping down from zero.
module mctc_core
    import mctc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic standby,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count events
    input wire logic [NUM_CH-1:0] count_tick,
    input wire logic [NUM_CH-1:0] count_down,
    input wire logic [NUM_CH-1:0] clear_req,
    input wire logic [NUM_GR-1:0] capture_strobe,
    // Pins
    output logic [NUM_CH-1:0] timer_io_pin,
    output logic [NUM_CH-1:0] overflow_flag,
    output logic [1:0] underflow_flag
);

    // ****************************************
    // State
    // ****************************************
    mctc_state_t s;
    mctc_state_t next_s;

    logic setup;
    logic wr;
    logic hit;
    logic [NUM_CH-1:0] cnt_wr;
    logic [NUM_GR-1:0] gr_wr;
    logic [NUM_CH-1:0] down;
    logic [NUM_CH-1:0] step;
    logic [NUM_CH-1:0] clr;
    logic [NUM_CH-1:0] match_a;
    logic [NUM_CH-1:0] match_b;
    logic [NUM_CH-1:0] new_run;
    logic sync_clr;
    logic sync_preset;
    logic [CNT_W-1:0] preset_val;
    logic [3:0] ia;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    // Registered answer: read data is caught in the setup cycle
    assign pready = psel & penable;
    assign prdata = s.rdata;
    assign pslverr = psel & penable & s.err;
    assign timer_io_pin = s.pin;
    assign overflow_flag = s.overflow_flag;
    assign underflow_flag = s.underflow_flag;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_s = s;
        cnt_wr = '0;
        gr_wr = '0;
        down = '0;
        step = '0;
        clr = '0;
        match_a = '0;
        match_b = '0;
        sync_clr = 1'b0;
        sync_preset = 1'b0;
        preset_val = COUNT_RST;
        ia = '0;
        hit = 1'b0;
        new_run = s.run_bits;

        // Address decode
        for (int i = 0; i < NUM_CH; i++) begin
            if (paddr == OFF_COUNT + ADDR_W'(i) * WORD_STEP) begin
                cnt_wr[i] = wr;
            end
        end
        for (int g = 0; g < NUM_GR; g++) begin
            if (paddr == OFF_GREG + ADDR_W'(g) * WORD_STEP) begin
                gr_wr[g] = wr;
            end
        end

        // Read path, sampled in the setup cycle
        if (setup) begin
            next_s.rdata = '0;
            next_s.err = 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (paddr == OFF_COUNT + ADDR_W'(i) * WORD_STEP) begin
                    next_s.rdata = {16'h0000, s.count[i]};
                    hit = 1'b1;
                end
            end
            for (int g = 0; g < NUM_GR; g++) begin
                if (paddr == OFF_GREG + ADDR_W'(g) * WORD_STEP) begin
                    next_s.rdata = {16'h0000, s.greg[g]};
                    hit = 1'b1;
                end
            end
            unique case (paddr)
                OFF_RUN: begin
                    next_s.rdata = {24'h000000, ch_to_byte(s.run_bits)};
                    hit = 1'b1;
                end
                OFF_SYNC: begin
                    next_s.rdata = {24'h000000, ch_to_byte(s.sync_bits)};
                    hit = 1'b1;
                end
                OFF_CTRL: begin
                    next_s.rdata[CTRL_CLR_LSB +: NUM_CH] = s.clr_en;
                    next_s.rdata[CTRL_UD1_BIT] = s.ud1;
                    next_s.rdata[CTRL_UD2_BIT] = s.ud2;
                    next_s.rdata[CTRL_CPWM_BIT] = s.cpwm;
                    next_s.rdata[CTRL_RPWM_BIT] = s.rpwm;
                    next_s.rdata[CTRL_BUF_LSB +: NUM_CH] = s.buf_en;
                    hit = 1'b1;
                end
                OFF_CAPSEL: begin
                    next_s.rdata = {16'h0000, s.capsel};
                    hit = 1'b1;
                end
                OFF_PINCTL: begin
                    next_s.rdata[PIN_INIT_LSB +: NUM_CH] = s.init_lvl;
                    next_s.rdata[PIN_LVL_LSB +: NUM_CH] = s.cmp_lvl;
                    hit = 1'b1;
                end
                OFF_FLAGS: begin
                    next_s.rdata[FLG_OVF_LSB +: NUM_CH] = s.overflow_flag;
                    next_s.rdata[FLG_UNF1_BIT] = s.underflow_flag[0];
                    next_s.rdata[FLG_UNF2_BIT] = s.underflow_flag[1];
                    hit = 1'b1;
                end
                default: begin
                end
            endcase
            next_s.err = ~hit;
        end

        // Control register writes
        if (wr) begin
            unique case (paddr)
                OFF_RUN: begin
                    new_run = byte_to_ch(pwdata);
                end
                OFF_SYNC: begin
                    next_s.sync_bits = byte_to_ch(pwdata);
                end
                OFF_CTRL: begin
                    next_s.clr_en = pwdata[CTRL_CLR_LSB +: NUM_CH];
                    next_s.ud1 = pwdata[CTRL_UD1_BIT];
                    next_s.ud2 = pwdata[CTRL_UD2_BIT];
                    next_s.cpwm = pwdata[CTRL_CPWM_BIT];
                    next_s.rpwm = pwdata[CTRL_RPWM_BIT];
                    next_s.buf_en = pwdata[CTRL_BUF_LSB +: NUM_CH];
                end
                OFF_CAPSEL: begin
                    next_s.capsel = pwdata[NUM_GR-1:0];
                end
                OFF_PINCTL: begin
                    next_s.init_lvl = pwdata[PIN_INIT_LSB +: NUM_CH];
                    next_s.cmp_lvl = pwdata[PIN_LVL_LSB +: NUM_CH];
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (!s.run_bits[i]) begin
                            next_s.pin[i] = pwdata[PIN_INIT_LSB + i];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        next_s.run_bits = new_run;

        // Direction per channel
        down[0] = 1'b0;
        down[1] = s.ud1 & count_down[1];
        down[2] = s.ud2 & count_down[2];
        down[3] = s.cpwm & count_down[3];
        down[4] = s.cpwm & count_down[4];
        step = s.run_bits & count_tick;

        // Compare matches
        for (int i = 0; i < NUM_CH; i++) begin
            ia = gr_a_idx(i);
            match_a[i] = s.run_bits[i] & ~s.capsel[ia] & (s.count[i] == s.greg[ia]);
            match_b[i] = s.run_bits[i] & ~s.capsel[ia + 4'h1] &
                (s.count[i] == s.greg[ia + 4'h1]);
        end

        // Clears and presets, shared among synchronized channels
        clr = clear_req & s.clr_en;
        sync_clr = |(clr & s.sync_bits);
        for (int i = 0; i < NUM_CH; i++) begin
            if (cnt_wr[i] && s.sync_bits[i]) begin
                sync_preset = 1'b1;
                preset_val = pwdata[CNT_W-1:0];
            end
        end

        // Counters: write, then clear, then count
        for (int i = 0; i < NUM_CH; i++) begin
            if (cnt_wr[i] || (sync_preset && s.sync_bits[i])) begin
                next_s.count[i] = sync_preset && s.sync_bits[i] ?
                    preset_val : pwdata[CNT_W-1:0];
            end else if (clr[i] || (sync_clr && s.sync_bits[i])) begin
                next_s.count[i] = COUNT_RST;
            end else if (step[i]) begin
                if (down[i]) begin
                    next_s.count[i] = s.count[i] - COUNT_ONE;
                    if (s.count[i] == COUNT_RST) begin
                        if (i == 1) begin
                            next_s.underflow_flag[0] = 1'b1;
                        end
                        if (i == 2) begin
                            next_s.underflow_flag[1] = 1'b1;
                        end
                    end
                end else begin
                    next_s.count[i] = s.count[i] + COUNT_ONE;
                    if (s.count[i] == COUNT_MAX) begin
                        next_s.overflow_flag[i] = 1'b1;
                    end
                end
            end
        end

        // Flag clears: zero written clears, a set in the same cycle wins
        if (wr && paddr == OFF_FLAGS) begin
            next_s.overflow_flag = next_s.overflow_flag &
                (~s.overflow_flag | pwdata[FLG_OVF_LSB +: NUM_CH] | next_s.overflow_flag &
                ~s.overflow_flag);
            if (!pwdata[FLG_UNF1_BIT] && s.underflow_flag[0]) begin
                next_s.underflow_flag[0] = 1'b0;
            end
            if (!pwdata[FLG_UNF2_BIT] && s.underflow_flag[1]) begin
                next_s.underflow_flag[1] = 1'b0;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (step[i] && !down[i] && s.count[i] == COUNT_MAX) begin
                    next_s.overflow_flag[i] = 1'b1;
                end
            end
            if (step[1] && down[1] && s.count[1] == COUNT_RST) begin
                next_s.underflow_flag[0] = 1'b1;
            end
            if (step[2] && down[2] && s.count[2] == COUNT_RST) begin
                next_s.underflow_flag[1] = 1'b1;
            end
        end

        // General registers: software write, capture, buffer transfer
        for (int g = 0; g < NUM_GR; g++) begin
            if (gr_wr[g]) begin
                next_s.greg[g] = pwdata[CNT_W-1:0];
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            ia = gr_a_idx(i);
            for (int k = 0; k < 4; k++) begin
                if ((k < 2 || has_four_gr(i)) && s.capsel[ia + 4'(k)] &&
                    capture_strobe[ia + 4'(k)]) begin
                    next_s.greg[ia + 4'(k)] = s.count[i];
                end
            end
            // Buffer pairs: C feeds A, D feeds B on compare match
            if (has_four_gr(i) && s.buf_en[i]) begin
                if (match_a[i]) begin
                    next_s.greg[ia] = s.greg[ia + 4'(GR_C_OFS)];
                end
                if (match_b[i]) begin
                    next_s.greg[ia + 4'h1] = s.greg[ia + 4'(GR_C_OFS) + 4'h1];
                end
            end
        end

        // Pin levels
        for (int i = 0; i < NUM_CH; i++) begin
            if (match_a[i]) begin
                next_s.pin[i] = s.cmp_lvl[i];
            end
            if (s.run_bits[i] && !new_run[i]) begin
                // Halting freezes the pin unless a PWM mode asks for restart level
                if (s.cpwm || s.rpwm) begin
                    next_s.pin[i] = s.init_lvl[i];
                end else begin
                    next_s.pin[i] = s.pin[i];
                end
            end
        end

        // Standby reinitialises like power-on, clock still running
        if (standby) begin
            next_s = '0;
            next_s.greg = {NUM_GR{GREG_RST}};
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.greg <= {NUM_GR{GREG_RST}};
        end else begin
            s <= next_s;
        end
    end

endmodule

// ==== mctc_pkg.sv ====
/*
 * Constants, register map and state type of the five-channel timer count core.
 * Assumes a 32-bit APB master and one peripheral clock.
 */
package mctc_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CH = 5;
    localparam int NUM_GR = 16;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int CH_W = 3;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_GREG = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_RUN = 8'h60;
    localparam logic [ADDR_W-1:0] OFF_SYNC = 8'h64;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h68;
    localparam logic [ADDR_W-1:0] OFF_CAPSEL = 8'h6C;
    localparam logic [ADDR_W-1:0] OFF_PINCTL = 8'h70;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h74;
    localparam logic [ADDR_W-1:0] WORD_STEP = 8'h04;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_CLR_LSB = 0;
    localparam int CTRL_UD1_BIT = 8;
    localparam int CTRL_UD2_BIT = 9;
    localparam int CTRL_CPWM_BIT = 10;
    localparam int CTRL_RPWM_BIT = 11;
    localparam int CTRL_BUF_LSB = 12;
    localparam int PIN_INIT_LSB = 0;
    localparam int PIN_LVL_LSB = 8;
    localparam int FLG_OVF_LSB = 0;
    localparam int FLG_UNF1_BIT = 8;
    localparam int FLG_UNF2_BIT = 9;
    localparam int BIT_CH4 = 7;
    localparam int BIT_CH3 = 6;

    // ****************************************
    // Reset values and count limits
    // ****************************************
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] GREG_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

    // ****************************************
    // Channel layout of the general registers
    // ****************************************
    localparam logic [CH_W-1:0] GR_A_CH0 = 3'h0;
    localparam logic [CH_W-1:0] GR_A_CH1 = 3'h4;
    localparam logic [CH_W-1:0] GR_A_CH2 = 3'h6;
    localparam logic [3:0] GR_A_CH3 = 4'h8;
    localparam logic [3:0] GR_A_CH4 = 4'hC;
    localparam int GR_C_OFS = 2;

    function automatic logic [3:0] gr_a_idx(input int ch);
        case (ch)
            0: gr_a_idx = 4'(GR_A_CH0);
            1: gr_a_idx = 4'(GR_A_CH1);
            2: gr_a_idx = 4'(GR_A_CH2);
            3: gr_a_idx = GR_A_CH3;
            default: gr_a_idx = GR_A_CH4;
        endcase
    endfunction

    function automatic logic has_four_gr(input int ch);
        has_four_gr = (ch == 0) || (ch == 3) || (ch == 4);
    endfunction

    // Channel vector to byte layout: ch4 bit 7, ch3 bit 6, ch2..0 bits 2..0
    function automatic logic [7:0] ch_to_byte(input logic [NUM_CH-1:0] v);
        ch_to_byte = {v[4], v[3], 3'h0, v[2:0]};
    endfunction

    function automatic logic [NUM_CH-1:0] byte_to_ch(input logic [31:0] d);
        byte_to_ch = {d[BIT_CH4], d[BIT_CH3], d[2:0]};
    endfunction

    // ****************************************
    // State of the core
    // ****************************************
    typedef struct packed {
        logic [NUM_CH-1:0][CNT_W-1:0] count;
        logic [NUM_GR-1:0][CNT_W-1:0] greg;
        logic [NUM_CH-1:0] run_bits;
        logic [NUM_CH-1:0] sync_bits;
        logic [NUM_CH-1:0] clr_en;
        logic ud1;
        logic ud2;
        logic cpwm;
        logic rpwm;
        logic [NUM_CH-1:0] buf_en;
        logic [NUM_GR-1:0] capsel;
        logic [NUM_CH-1:0] init_lvl;
        logic [NUM_CH-1:0] cmp_lvl;
        logic [NUM_CH-1:0] pin;
        logic [NUM_CH-1:0] overflow_flag;
        logic [1:0] underflow_flag;
        logic [31:0] rdata;
        logic err;
    } mctc_state_t;

endpackage

// ==== mctc_core_chk.sv ====
/*
 * Port-level checker for the five-channel timer count core.
 * Assumes it is bound to mctc_core and sees only its ports.
 */
`timescale 1ns/1ps

module mctc_core_chk
    import mctc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic standby,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Count events
    input wire logic [NUM_CH-1:0] count_tick,
    input wire logic [NUM_CH-1:0] count_down,
    input wire logic [NUM_CH-1:0] clear_req,
    input wire logic [NUM_GR-1:0] capture_strobe,
    // Pins
    input wire logic [NUM_CH-1:0] timer_io_pin,
    input wire logic [NUM_CH-1:0] overflow_flag,
    input wire logic [1:0] underflow_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // Register access
    // ****************************************
    a_run_map_ok: assert property (psel && penable && paddr == OFF_RUN |-> pready && !pslverr)
        else $error("run register access refused");
    a_sync_map_ok: assert property (psel && penable && paddr == OFF_SYNC |-> pready && !pslverr)
        else $error("sync register access refused");
    a_run_rsvd_zero: assert property (psel && penable && !pwrite && paddr == OFF_RUN |-> prdata[5:3] == 3'h0 && prdata[31:8] == 24'h0)
        else $error("run register reserved bits read nonzero");
    a_sync_rsvd_zero: assert property (psel && penable && !pwrite && paddr == OFF_SYNC |-> prdata[5:3] == 3'h0 && prdata[31:8] == 24'h0)
        else $error("sync register reserved bits read nonzero");

    // ****************************************
    // Flags and pins
    // ****************************************
    // A wrap can only come from a counted step
    a_ovf_needs_tick: assert property (|(overflow_flag & ~$past(overflow_flag) & ~$past(count_tick)) == 1'b0)
        else $error("overflow flag set without a count tick");
    a_unf_needs_down: assert property ($rose(underflow_flag[0]) |-> $past(count_tick[1] && count_down[1]))
        else $error("underflow flag set without a down tick");
    a_ovf_sticky: assert property (|($past(overflow_flag) & ~overflow_flag) |-> $past(standby || psel && penable && pwrite && paddr == OFF_FLAGS))
        else $error("overflow flag cleared without cause");
    a_flags_standby: assert property (standby |=> overflow_flag == 5'h00 && underflow_flag == 2'h0)
        else $error("flags survive standby");
    a_pin_standby: assert property (standby ##1 standby |-> timer_io_pin == 5'h00)
        else $error("pins not at reset level in standby");
endmodule

bind mctc_core mctc_core_chk u_chk (.pclk(pclk), .presetn(presetn), .standby(standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
    .count_down(count_down), .clear_req(clear_req), .capture_strobe(capture_strobe),
    .timer_io_pin(timer_io_pin), .overflow_flag(overflow_flag),
    .underflow_flag(underflow_flag));

// ==== multichannel_timer_count_core_tb_top.sv ====
/*
 * Self-checking testbench for the five-channel timer count core.
 * Assumes zero-wait-state APB and single-cycle count event pulses.
 */
`timescale 1ns/1ps

module multichannel_timer_count_core_tb_top
    import mctc_pkg::*;
;
    // ****************************************
    // Stimulus signals
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic standby = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_CH-1:0] count_tick = '0;
    logic [NUM_CH-1:0] count_down = '0;
    logic [NUM_CH-1:0] clear_req = '0;
    logic [NUM_GR-1:0] capture_strobe = '0;
    logic [NUM_CH-1:0] timer_io_pin;
    logic [NUM_CH-1:0] overflow_flag;
    logic [1:0] underflow_flag;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] q;
    logic e;

    always #4 pclk = ~pclk;

    mctc_core DUT (.pclk(pclk), .presetn(presetn), .standby(standby), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_tick(count_tick), .count_down(count_down),
        .clear_req(clear_req), .capture_strobe(capture_strobe), .timer_io_pin(timer_io_pin),
        .overflow_flag(overflow_flag), .underflow_flag(underflow_flag));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hangs are cut by a cycle ceiling well above the few hundred cycles needed
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            err_total = err_total + 1;
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, q, exp);
    endtask

    task automatic tick(input logic [NUM_CH-1:0] m, input logic [NUM_CH-1:0] dn);
        @(posedge pclk);
        count_tick <= m;
        count_down <= dn;
        @(posedge pclk);
        count_tick <= '0;
        count_down <= '0;
    endtask

    function automatic logic [ADDR_W-1:0] ca(input int i);
        ca = OFF_COUNT + 8'(4 * i);
    endfunction

    function automatic logic [ADDR_W-1:0] ga(input int g);
        ga = OFF_GREG + 8'(4 * g);
    endfunction

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < NUM_CH; i++) rd("count reset", ca(i), 32'h0000_0000);
        for (int g = 0; g < NUM_GR; g++) rd("greg reset", ga(g), 32'h0000_FFFF);
        rd("run reset", OFF_RUN, 32'h0000_0000);
        rd("sync reset", OFF_SYNC, 32'h0000_0000);
        $display("test reset values done");

        // Sixteen distinct registers, each holding a full 16-bit value
        for (int g = 0; g < NUM_GR; g++) wr(ga(g), 32'h0000_A500 + 32'(g));
        for (int g = 0; g < NUM_GR; g++) rd("greg rw", ga(g), 32'h0000_A500 + 32'(g));
        wr(ca(2), 32'h0000_5AC3);
        rd("count rw", ca(2), 32'h0000_5AC3);
        wr(ca(2), 32'h0000_0000);
        // Reserved bits are written as zero, so reading them back tests the read path only
        wr(OFF_RUN, 32'h0000_00C7);
        rd("run layout", OFF_RUN, 32'h0000_00C7);
        wr(OFF_SYNC, 32'h0000_00C7);
        rd("sync layout", OFF_SYNC, 32'h0000_00C7);
        wr(OFF_RUN, 32'h0000_0000);
        wr(OFF_SYNC, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 32'(e), 32'h1);
        chk("unmapped data", q, 32'h0);
        $display("test register access done");

        wr(ca(0), 32'h0000_FFFE);
        tick(5'h01, 5'h00);
        rd("halted count", ca(0), 32'h0000_FFFE);
        wr(OFF_RUN, 32'h0000_0001);
        tick(5'h01, 5'h01);
        rd("ch0 up only", ca(0), 32'h0000_FFFF);
        tick(5'h01, 5'h00);
        @(negedge pclk);
        chk("ovf flag", 32'(overflow_flag), 32'h0000_0001);
        rd("ch0 wrap", ca(0), 32'h0000_0000);
        $display("test ch0 counting done");

        wr(OFF_RUN, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0100);
        wr(OFF_RUN, 32'h0000_0002);
        tick(5'h02, 5'h02);
        @(negedge pclk);
        chk("unf flag", 32'(underflow_flag), 32'h0000_0001);
        rd("ch1 down", ca(1), 32'h0000_FFFF);
        wr(OFF_CTRL, 32'h0000_0000);
        wr(ca(3), 32'h0000_0005);
        wr(OFF_RUN, 32'h0000_0040);
        tick(5'h08, 5'h08);
        rd("ch3 up outside pwm", ca(3), 32'h0000_0006);
        wr(OFF_CTRL, 32'h0000_0400);
        tick(5'h08, 5'h08);
        rd("ch3 down in pwm", ca(3), 32'h0000_0005);
        $display("test directions done");

        wr(OFF_RUN, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_SYNC, 32'h0000_0003);
        wr(ca(0), 32'h0000_1234);
        rd("sync preset", ca(1), 32'h0000_1234);
        rd("independent", ca(2), 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0003);
        wr(OFF_RUN, 32'h0000_0003);
        @(posedge pclk);
        clear_req <= 5'h01;
        @(posedge pclk);
        clear_req <= 5'h00;
        rd("sync clear", ca(1), 32'h0000_0000);
        $display("test synchronization done");

        wr(OFF_RUN, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_PINCTL, 32'h0000_0015);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("pin initial level", 32'(timer_io_pin), 32'h0000_0015);
        $display("test pin level done");

        wr(OFF_RUN, 32'h0000_0001);
        wr(OFF_SYNC, 32'h0000_0003);
        @(posedge pclk);
        standby <= 1'b1;
        repeat (2) @(posedge pclk);
        standby <= 1'b0;
        rd("standby count", ca(3), 32'h0000_0000);
        rd("standby greg", ga(5), 32'h0000_FFFF);
        rd("standby run", OFF_RUN, 32'h0000_0000);
        rd("standby sync", OFF_SYNC, 32'h0000_0000);
        $display("test standby done");

        // Match on A drives the pin and reloads A from C; one step avoids a second match
        wr(ga(0), 32'h0000_0003);
        wr(ga(2), 32'h0000_0010);
        wr(OFF_CTRL, 32'h0000_1000);
        wr(OFF_PINCTL, 32'h0000_0100);
        wr(ca(0), 32'h0000_0002);
        wr(OFF_RUN, 32'h0000_0001);
        tick(5'h01, 5'h00);
        wr(OFF_RUN, 32'h0000_0000);
        rd("buffer load", ga(0), 32'h0000_0010);
        chk("pin held", 32'(timer_io_pin), 32'h0000_0001);
        wr(OFF_RUN, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0800);
        wr(OFF_RUN, 32'h0000_0000);
        rd("halted ch0", ca(0), 32'h0000_0003);
        chk("pin pwm halt", 32'(timer_io_pin), 32'h0000_0000);
        $display("test compare and halt done");
        results();
    end
endmodule
